// ===== verif/afs_host_model.sv
// host side model driving the register access strobes
module afs_host_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk);
    #1 {reg_rd, reg_addr} = {1'b0, ~a};
    d = reg_rdata;
  endtask
endmodule // afs_host_model

// ===== verif/afs_regs_sva.sv
// assertions on the fault and diagnostic register bank ports
module afs_regs_sva (
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [7:0]                reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      invalid_clock,
  input wire logic                      fault_pin_n,
  input wire logic                      warn_pin_n,
  input wire logic                      first_diag_run,
  input wire logic                      second_diag_run,
  input wire logic                      first_diag_gain4,
  input wire logic                      second_diag_gain4,
  input wire logic                      impedance_test_return_path,
  input wire logic [6:0]                impedance_test_length,
  input wire afs_pkg::afs_test_current_t impedance_test_current
);
  import afs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_clk_pin; invalid_clock |-> ##2 !fault_pin_n; endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("clock fault not on pin");
  property p_unmapped; reg_rd && reg_addr == 8'h19 |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_run; reg_wr && reg_addr == 8'h15 |-> ##2
    {first_diag_run, second_diag_run} == $past(reg_wdata[3:2], 2); endproperty
  a_run: assert property (p_run) else $error("diag run wrong");
  property p_gain; reg_wr && reg_addr == 8'h15 |-> ##2
    {first_diag_gain4, second_diag_gain4} == $past(reg_wdata[7:6], 2); endproperty
  a_gain: assert property (p_gain) else $error("diag gain wrong");
  property p_len; reg_wr && reg_addr == 8'h16 |-> ##2
    impedance_test_length == ($past(reg_wdata[4], 2) ? 7'd64 : 7'd32); endproperty
  a_len: assert property (p_len) else $error("test length wrong");
  property p_loop; reg_wr && reg_addr == 8'h16 |-> ##2
    impedance_test_return_path == $past(reg_wdata[7], 2); endproperty
  a_loop: assert property (p_loop) else $error("return path wrong");
  property p_cur; reg_wr && reg_addr == 8'h16 |-> ##2
    impedance_test_current == $past(reg_wdata[3:2], 2); endproperty
  a_cur: assert property (p_cur) else $error("test current wrong");
  property p_rst; $rose(nrst) |-> fault_pin_n && warn_pin_n && impedance_test_length == 7'd32;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset level");
  c_fault: cover property (!fault_pin_n);
  c_warn: cover property (!warn_pin_n);
  c_long: cover property (impedance_test_length == 7'd64);
endmodule // afs_regs_sva
bind afs_regs afs_regs_sva chk_u (.*);

// ===== verif/amp_fault_status_and_ac_diag_regs_tb_top.sv
// self-checking bench for the fault and diagnostic register bank
module amp_fault_status_and_ac_diag_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import afs_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, clip_event, result_valid, fault_pin_n, warn_pin_n;
  logic first_diag_run, second_diag_run, first_diag_gain4, second_diag_gain4;
  logic impedance_test_return_path;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, result_imp_ch1, result_imp_ch2, d, m;
  logic [15:0] result_phase, result_metric;
  logic [14:0] f;
  logic [6:0] impedance_test_length;
  afs_test_current_t impedance_test_current;
  afs_chan_state_t s1, s2;
  int err_count, checked, cyc;
  logic [7:0] bm [15] = '{8'h80,8'h40,8'h08,8'h04,8'h10,8'h08,8'h04,8'h02,8'h01,8'h10,8'h08,
                          8'h04,8'h10,8'h08,8'h04};
  logic [7:0] mk [15] = '{8'h80,8'h80,8'h08,8'h08,8'h00,8'h10,8'h10,8'h20,8'h20,8'h40,8'h40,
                          8'h40,8'h01,8'h01,8'h01};
  logic [7:0] ad [16] = '{8'h0F,8'h10,8'h11,8'h12,8'h13,8'h14,8'h15,8'h16,8'h17,8'h18,8'h1B,
                          8'h1C,8'h1D,8'h1E,8'h21,8'h19};
  afs_host_model host_u (.*);
  afs_regs dut_u (.*, .first_channel_state(s1), .second_channel_state(s2),
    .first_channel_overcurrent(f[0]), .second_channel_overcurrent(f[1]),
    .first_channel_offset_fault(f[2]), .second_channel_offset_fault(f[3]),
    .invalid_clock(f[4]), .power_stage_supply_high(f[5]), .battery_supply_high(f[6]),
    .power_stage_supply_low(f[7]), .battery_supply_low(f[8]), .thermal_shutdown_flag(f[9]),
    .first_thermal_shutdown(f[10]), .second_thermal_shutdown(f[11]),
    .thermal_warning_flag(f[12]), .first_thermal_warning(f[13]),
    .second_thermal_warning(f[14]));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    chk_reg({7'h00, g}, {7'h00, e});
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    #1 f[i] = 1'b1;
    @(posedge clk);
    #1 f[i] = 1'b0;
  endtask
  task automatic wrap_up;
    $display("comparisons=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up;
    end
  end
  initial begin
    {nrst, clip_event, result_valid, f, result_phase, result_metric} = '0;
    {result_imp_ch1, result_imp_ch2} = '0;
    {s1, s2} = {AFS_HIZ, AFS_HIZ};
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    for (int k = 0; k < 16; k++) begin
      host_u.rd(ad[k], d);
      chk_reg(d, k == 0 ? 8'h55 : k == 4 ? 8'h20 : 8'h00);
      host_u.wr(ad[k], 8'hA5);
      host_u.rd(ad[k], d);
      m = (k == 0) ? 8'h55 : (k == 4) ? 8'h20 : (k inside {5, 6, 7, 14}) ? 8'hA5 : 8'h00;
      chk_reg(d, m);
    end
    for (int k = 5; k < 15; k += (k == 7) ? 7 : 1) host_u.wr(ad[k], 8'h00);
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 15; i++) begin
        host_u.wr(8'h14, p ? mk[i] : 8'h00);
        pulse(i);
        m = i < 4 ? 8'h10 : i < 9 ? 8'h11 : i < 12 ? 8'h12 : 8'h13;
        host_u.rd(m, d);
        chk_reg(d, bm[i]);
        chk_pin(i < 12 ? fault_pin_n : warn_pin_n, p && mk[i] != 8'h00);
        host_u.wr(8'h21, 8'h00);
        host_u.rd(m, d);
        chk_reg(d, bm[i]);
        host_u.wr(8'h21, 8'h80);
        host_u.wr(8'h21, 8'h00);
        host_u.rd(m, d);
        chk_reg(d, 8'h00);
        chk_pin(fault_pin_n & warn_pin_n, 1'b1);
      end
    for (int k = 0; k < 4; k++) begin
      {s1, s2} = {2'(k), 2'(3 - k)};
      host_u.rd(8'h0F, d);
      chk_reg(d, {2'(k), 2'(3 - k), 4'h5});
    end
    host_u.wr(8'h21, 8'h08);
    pulse(9);
    repeat (2) @(posedge clk);
    host_u.rd(8'h12, d);
    chk_reg(d, 8'h00);
    host_u.wr(8'h21, 8'h00);
    host_u.wr(8'h15, 8'hCC);
    host_u.wr(8'h16, 8'h94);
    repeat (2) @(posedge clk);
    chk_reg({first_diag_run, second_diag_run, first_diag_gain4, second_diag_gain4,
      impedance_test_return_path, 3'h0}, 8'hF8);
    chk_reg({impedance_test_length, 1'b0}, 8'h80);
    chk_reg({6'h00, impedance_test_current}, 8'h01);
    host_u.wr(8'h16, 8'h00);
    host_u.wr(8'h15, 8'h08);
    repeat (2) @(posedge clk);
    chk_reg({1'b0, impedance_test_length}, 8'h20);
    chk_reg({5'h00, impedance_test_current, second_diag_run}, 8'h00);
    for (int q = 0; q < 2; q++) begin
      @(posedge clk);
      #1 {result_valid, result_imp_ch1, result_imp_ch2} = {1'b1, 8'hA5 ^ 8'(q), 8'h5A};
      {result_phase, result_metric} = {16'h1234 + 16'(q), 16'hABCD};
      @(posedge clk);
      #1 result_valid = 1'b0;
      for (int k = 8; k < 14; k++) begin
        host_u.rd(ad[k], d);
        m = k == 8 ? 8'hA5 ^ 8'(q) : k == 9 ? (q ? 8'h5A : 8'h00) : k == 10 ? 8'h12 :
          k == 11 ? 8'h34 + 8'(q) : k == 12 ? 8'hAB : 8'hCD;
        chk_reg(d, m);
      end
      host_u.wr(8'h15, 8'h0C);
    end
    @(posedge clk);
    #1 clip_event = 1'b1;
    repeat (3) @(posedge clk);
    chk_pin(warn_pin_n, 1'b0);
    host_u.wr(8'h14, 8'h02);
    repeat (2) @(posedge clk);
    chk_pin(warn_pin_n, 1'b1);
    wrap_up;
  end
endmodule // amp_fault_status_and_ac_diag_regs_tb_top

// ===== verilog/afs_map.svh
// register offsets, field positions, reset values and codes for the fault/diag bank
`ifndef AFS_MAP_SVH
`define AFS_MAP_SVH
`define AFS_OFF_STATE      8'h0F
`define AFS_OFF_CHFLT      8'h10
`define AFS_OFF_GFLT1      8'h11
`define AFS_OFF_GFLT2      8'h12
`define AFS_OFF_WARN       8'h13
`define AFS_OFF_PINMASK    8'h14
`define AFS_OFF_ACCTL1     8'h15
`define AFS_OFF_ACCTL2     8'h16
`define AFS_OFF_IMP1       8'h17
`define AFS_OFF_IMP2       8'h18
`define AFS_OFF_PHASE_HI   8'h1B
`define AFS_OFF_PHASE_LO   8'h1C
`define AFS_OFF_STI_HI     8'h1D
`define AFS_OFF_STI_LO     8'h1E
`define AFS_OFF_MISC3      8'h21
`define AFS_RST_ZERO       8'h00
`define AFS_RST_WARN       8'h20
`define AFS_RST_STATE      2'h1
`define AFS_STATE_RSVD     4'h5
`define AFS_BIT_FIRST_CHANNEL_OVERCURRENT     7
`define AFS_BIT_SECOND_CHANNEL_OVERCURRENT     6
`define AFS_BIT_FIRST_CHANNEL_OFFSET_FAULT     3
`define AFS_BIT_SECOND_CHANNEL_OFFSET_FAULT     2
`define AFS_BIT_CLK        4
`define AFS_BIT_PS_OV      3
`define AFS_BIT_BAT_OV     2
`define AFS_BIT_PS_UV      1
`define AFS_BIT_BAT_UV     0
`define AFS_BIT_THERMAL_SHUTDOWN_FLAG       4
`define AFS_BIT_CH1_THERMAL_SHUTDOWN_FLAG   3
`define AFS_BIT_CH2_THERMAL_SHUTDOWN_FLAG   2
`define AFS_BIT_POR        5
`define AFS_BIT_OTW        4
`define AFS_BIT_CH1_OTW    3
`define AFS_BIT_CH2_OTW    2
`define AFS_BIT_M_OC       7
`define AFS_BIT_M_THERMAL_SHUTDOWN_FLAG     6
`define AFS_BIT_M_UV       5
`define AFS_BIT_M_OV       4
`define AFS_BIT_M_DC       3
`define AFS_BIT_M_CLIP     1
`define AFS_BIT_M_OTW      0
`define AFS_BIT_CH1_GAIN   7
`define AFS_BIT_CH2_GAIN   6
`define AFS_BIT_CH1_EN     3
`define AFS_BIT_CH2_EN     2
`define AFS_BIT_LOOPBACK   7
`define AFS_BIT_LENGTH     4
`define AFS_BIT_CUR_HI     3
`define AFS_BIT_CUR_LO     2
`define AFS_BIT_CLEAR      7
`define AFS_BIT_AUTOREC    3
`define AFS_LEN_SHORT      7'd32
`define AFS_LEN_LONG       7'd64
`endif

// ===== verilog/afs_pkg.sv
// types for the fault/diag register bank
package afs_pkg;
  typedef enum logic [1:0] {
    AFS_PLAY  = 2'h0,
    AFS_HIZ   = 2'h1,
    AFS_MUTE  = 2'h2,
    AFS_DCDIAG = 2'h3
  } afs_chan_state_t;
  typedef enum logic [1:0] {
    AFS_CUR_10MA = 2'h0,
    AFS_CUR_19MA = 2'h1
  } afs_test_current_t;
endpackage

// ===== verilog/afs_regs.sv
// fault, warning, pin-mask and ac diagnostic register bank
`include "afs_map.svh"
module afs_regs (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  output logic      [7:0]                   reg_rdata,
  input  wire afs_pkg::afs_chan_state_t     first_channel_state,
  input  wire afs_pkg::afs_chan_state_t     second_channel_state,
  input  wire logic                         first_channel_overcurrent,
  input  wire logic                         second_channel_overcurrent,
  input  wire logic                         first_channel_offset_fault,
  input  wire logic                         second_channel_offset_fault,
  input  wire logic                         invalid_clock,
  input  wire logic                         power_stage_supply_high,
  input  wire logic                         battery_supply_high,
  input  wire logic                         power_stage_supply_low,
  input  wire logic                         battery_supply_low,
  input  wire logic                         thermal_shutdown_flag,
  input  wire logic                         first_thermal_shutdown,
  input  wire logic                         second_thermal_shutdown,
  input  wire logic                         thermal_warning_flag,
  input  wire logic                         first_thermal_warning,
  input  wire logic                         second_thermal_warning,
  input  wire logic                         clip_event,
  input  wire logic                         result_valid,
  input  wire logic [7:0]                   result_imp_ch1,
  input  wire logic [7:0]                   result_imp_ch2,
  input  wire logic [15:0]                  result_phase,
  input  wire logic [15:0]                  result_metric,
  output logic                              fault_pin_n,
  output logic                              warn_pin_n,
  output logic                              first_diag_run,
  output logic                              second_diag_run,
  output logic                              first_diag_gain4,
  output logic                              second_diag_gain4,
  output logic                              impedance_test_return_path,
  output logic      [6:0]                   impedance_test_length,
  output afs_pkg::afs_test_current_t        impedance_test_current
);
  import afs_pkg::*;

  // flag registers
  logic [7:0]  state_q;
  logic [7:0]  chflt_q;
  logic [7:0]  gflt1_q;
  logic [7:0]  gflt2_q;
  logic [7:0]  warn_q;
  // control registers
  logic [7:0]  pinmask_q;
  logic [7:0]  acctl1_q;
  logic [7:0]  acctl2_q;
  logic [7:0]  misc3_q;
  // result captures
  logic [7:0]  imp1_q;
  logic [7:0]  imp2_q;
  logic [15:0] phase_q;
  logic [15:0] metric_q;
  // next values and decode
  logic [7:0]  state_d;
  logic [7:0]  chflt_d;
  logic [7:0]  gflt1_d;
  logic [7:0]  gflt2_d;
  logic [7:0]  warn_d;
  logic [7:0]  rdata_d;
  logic [6:0]  length_d;
  afs_test_current_t current_d;
  logic        clear_wr;
  logic        pinmask_wr;
  logic        acctl1_wr;
  logic        acctl2_wr;
  logic        misc3_wr;
  // fault and warning pin classes
  logic        oc_class;
  logic        dc_class;
  logic        ov_class;
  logic        uv_class;
  logic        thermal_shutdown_flag_class;
  logic        clk_class;
  logic        otw_class;
  logic        clip_class;
  logic        fault_any;
  logic        warn_any;

  // address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // write strobe for one offset
  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
    wr_hit = wr && hit(a, off);
  endfunction

  // write strobes for the four writable registers
  assign pinmask_wr = wr_hit(reg_wr, reg_addr, `AFS_OFF_PINMASK);
  assign acctl1_wr  = wr_hit(reg_wr, reg_addr, `AFS_OFF_ACCTL1);
  assign acctl2_wr  = wr_hit(reg_wr, reg_addr, `AFS_OFF_ACCTL2);
  assign misc3_wr   = wr_hit(reg_wr, reg_addr, `AFS_OFF_MISC3);

  // clear strobe only while the control bit is written high
  assign clear_wr = misc3_wr && reg_wdata[`AFS_BIT_CLEAR];

  // live state, reserved pairs read 01
  assign state_d = {first_channel_state, second_channel_state, `AFS_STATE_RSVD};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= {`AFS_RST_STATE, `AFS_RST_STATE, `AFS_STATE_RSVD};
    end else begin
      state_q <= state_d;
    end
  end

  // channel faults: sticky, a set in the clear cycle wins
  always_comb begin
    chflt_d = clear_wr ? `AFS_RST_ZERO : chflt_q;
    chflt_d[`AFS_BIT_FIRST_CHANNEL_OVERCURRENT] = chflt_d[`AFS_BIT_FIRST_CHANNEL_OVERCURRENT] | first_channel_overcurrent;
    chflt_d[`AFS_BIT_SECOND_CHANNEL_OVERCURRENT] = chflt_d[`AFS_BIT_SECOND_CHANNEL_OVERCURRENT] | second_channel_overcurrent;
    chflt_d[`AFS_BIT_FIRST_CHANNEL_OFFSET_FAULT] = chflt_d[`AFS_BIT_FIRST_CHANNEL_OFFSET_FAULT] | first_channel_offset_fault;
    chflt_d[`AFS_BIT_SECOND_CHANNEL_OFFSET_FAULT] = chflt_d[`AFS_BIT_SECOND_CHANNEL_OFFSET_FAULT] | second_channel_offset_fault;
  end

  // global faults one: clock and supplies
  always_comb begin
    gflt1_d = clear_wr ? `AFS_RST_ZERO : gflt1_q;
    gflt1_d[`AFS_BIT_CLK]    = gflt1_d[`AFS_BIT_CLK] | invalid_clock;
    gflt1_d[`AFS_BIT_PS_OV]  = gflt1_d[`AFS_BIT_PS_OV] | power_stage_supply_high;
    gflt1_d[`AFS_BIT_BAT_OV] = gflt1_d[`AFS_BIT_BAT_OV] | battery_supply_high;
    gflt1_d[`AFS_BIT_PS_UV]  = gflt1_d[`AFS_BIT_PS_UV] | power_stage_supply_low;
    gflt1_d[`AFS_BIT_BAT_UV] = gflt1_d[`AFS_BIT_BAT_UV] | battery_supply_low;
  end

  // global faults two: auto-restart mode follows the live condition
  always_comb begin
    if (misc3_q[`AFS_BIT_AUTOREC]) begin
      gflt2_d = `AFS_RST_ZERO;
    end else begin
      gflt2_d = clear_wr ? `AFS_RST_ZERO : gflt2_q;
    end
    gflt2_d[`AFS_BIT_THERMAL_SHUTDOWN_FLAG]     = gflt2_d[`AFS_BIT_THERMAL_SHUTDOWN_FLAG] | thermal_shutdown_flag;
    gflt2_d[`AFS_BIT_CH1_THERMAL_SHUTDOWN_FLAG] = gflt2_d[`AFS_BIT_CH1_THERMAL_SHUTDOWN_FLAG] | first_thermal_shutdown;
    gflt2_d[`AFS_BIT_CH2_THERMAL_SHUTDOWN_FLAG] = gflt2_d[`AFS_BIT_CH2_THERMAL_SHUTDOWN_FLAG] | second_thermal_shutdown;
  end

  // warnings, power-on mark cleared with the faults
  always_comb begin
    warn_d = clear_wr ? `AFS_RST_ZERO : warn_q;
    warn_d[`AFS_BIT_OTW]     = warn_d[`AFS_BIT_OTW] | thermal_warning_flag;
    warn_d[`AFS_BIT_CH1_OTW] = warn_d[`AFS_BIT_CH1_OTW] | first_thermal_warning;
    warn_d[`AFS_BIT_CH2_OTW] = warn_d[`AFS_BIT_CH2_OTW] | second_thermal_warning;
  end

  // channel fault register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chflt_q <= `AFS_RST_ZERO;
    end else begin
      chflt_q <= chflt_d;
    end
  end

  // global fault register one
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gflt1_q <= `AFS_RST_ZERO;
    end else begin
      gflt1_q <= gflt1_d;
    end
  end

  // global fault register two
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gflt2_q <= `AFS_RST_ZERO;
    end else begin
      gflt2_q <= gflt2_d;
    end
  end

  // warning register, power-on mark set by reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      warn_q <= `AFS_RST_WARN;
    end else begin
      warn_q <= warn_d;
    end
  end

  // pin mask register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pinmask_q <= `AFS_RST_ZERO;
    end else if (pinmask_wr) begin
      pinmask_q <= reg_wdata;
    end
  end

  // ac control one
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acctl1_q <= `AFS_RST_ZERO;
    end else if (acctl1_wr) begin
      acctl1_q <= reg_wdata;
    end
  end

  // ac control two
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acctl2_q <= `AFS_RST_ZERO;
    end else if (acctl2_wr) begin
      acctl2_q <= reg_wdata;
    end
  end

  // misc three, clear bit stays stored as written
  always_ff @(posedge clk) begin
    if (!nrst) begin
      misc3_q <= `AFS_RST_ZERO;
    end else if (misc3_wr) begin
      misc3_q <= reg_wdata;
    end
  end

  // impedance results, enabled channels only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      imp1_q <= `AFS_RST_ZERO;
      imp2_q <= `AFS_RST_ZERO;
    end else if (result_valid) begin
      if (acctl1_q[`AFS_BIT_CH1_EN]) begin
        imp1_q <= result_imp_ch1;
      end
      if (acctl1_q[`AFS_BIT_CH2_EN]) begin
        imp2_q <= result_imp_ch2;
      end
    end
  end

  // phase and metric, both bytes from one capture
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_q  <= {`AFS_RST_ZERO, `AFS_RST_ZERO};
      metric_q <= {`AFS_RST_ZERO, `AFS_RST_ZERO};
    end else if (result_valid) begin
      phase_q  <= result_phase;
      metric_q <= result_metric;
    end
  end

  // overcurrent class
  assign oc_class   = !pinmask_q[`AFS_BIT_M_OC] &&
                      (chflt_q[`AFS_BIT_FIRST_CHANNEL_OVERCURRENT] || chflt_q[`AFS_BIT_SECOND_CHANNEL_OVERCURRENT]);
  // dc offset class
  assign dc_class   = !pinmask_q[`AFS_BIT_M_DC] &&
                      (chflt_q[`AFS_BIT_FIRST_CHANNEL_OFFSET_FAULT] || chflt_q[`AFS_BIT_SECOND_CHANNEL_OFFSET_FAULT]);
  // overvoltage class
  assign ov_class   = !pinmask_q[`AFS_BIT_M_OV] &&
                      (gflt1_q[`AFS_BIT_PS_OV] || gflt1_q[`AFS_BIT_BAT_OV]);
  // undervoltage class
  assign uv_class   = !pinmask_q[`AFS_BIT_M_UV] &&
                      (gflt1_q[`AFS_BIT_PS_UV] || gflt1_q[`AFS_BIT_BAT_UV]);
  // thermal shutdown class
  assign thermal_shutdown_flag_class = !pinmask_q[`AFS_BIT_M_THERMAL_SHUTDOWN_FLAG] &&
                      (gflt2_q[`AFS_BIT_THERMAL_SHUTDOWN_FLAG] || gflt2_q[`AFS_BIT_CH1_THERMAL_SHUTDOWN_FLAG] ||
                       gflt2_q[`AFS_BIT_CH2_THERMAL_SHUTDOWN_FLAG]);
  // clock fault has no mask class
  assign clk_class  = gflt1_q[`AFS_BIT_CLK];
  // thermal warning class
  assign otw_class  = !pinmask_q[`AFS_BIT_M_OTW] &&
                      (warn_q[`AFS_BIT_OTW] || warn_q[`AFS_BIT_CH1_OTW] ||
                       warn_q[`AFS_BIT_CH2_OTW]);
  // live clip, not latched here
  assign clip_class = !pinmask_q[`AFS_BIT_M_CLIP] && clip_event;

  // any unmasked class drives its pin
  assign fault_any = oc_class || dc_class || ov_class || uv_class || thermal_shutdown_flag_class || clk_class;
  assign warn_any  = otw_class || clip_class;

  // diagnostic length and current decode
  assign length_d  = acctl2_q[`AFS_BIT_LENGTH] ? `AFS_LEN_LONG : `AFS_LEN_SHORT;
  assign current_d = afs_test_current_t'(acctl2_q[`AFS_BIT_CUR_HI:`AFS_BIT_CUR_LO]);

  // read mux, no side effects
  always_comb begin
    case (reg_addr)
      `AFS_OFF_STATE:    rdata_d = state_q;
      `AFS_OFF_CHFLT:    rdata_d = chflt_q;
      `AFS_OFF_GFLT1:    rdata_d = gflt1_q;
      `AFS_OFF_GFLT2:    rdata_d = gflt2_q;
      `AFS_OFF_WARN:     rdata_d = warn_q;
      `AFS_OFF_PINMASK:  rdata_d = pinmask_q;
      `AFS_OFF_ACCTL1:   rdata_d = acctl1_q;
      `AFS_OFF_ACCTL2:   rdata_d = acctl2_q;
      `AFS_OFF_IMP1:     rdata_d = imp1_q;
      `AFS_OFF_IMP2:     rdata_d = imp2_q;
      `AFS_OFF_PHASE_HI: rdata_d = phase_q[15:8];
      `AFS_OFF_PHASE_LO: rdata_d = phase_q[7:0];
      `AFS_OFF_STI_HI:   rdata_d = metric_q[15:8];
      `AFS_OFF_STI_LO:   rdata_d = metric_q[7:0];
      `AFS_OFF_MISC3:    rdata_d = misc3_q;
      default:           rdata_d = `AFS_RST_ZERO;
    endcase
  end

  // read data register, moves only on a read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= `AFS_RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // indicator pins, released high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_pin_n <= 1'b1;
      warn_pin_n  <= 1'b1;
    end else begin
      fault_pin_n <= !fault_any;
      warn_pin_n  <= !warn_any;
    end
  end

  // diagnostic run and gain selects
  always_ff @(posedge clk) begin
    if (!nrst) begin
      first_diag_run    <= 1'b0;
      second_diag_run   <= 1'b0;
      first_diag_gain4  <= 1'b0;
      second_diag_gain4 <= 1'b0;
    end else begin
      first_diag_run    <= acctl1_q[`AFS_BIT_CH1_EN];
      second_diag_run   <= acctl1_q[`AFS_BIT_CH2_EN];
      first_diag_gain4  <= acctl1_q[`AFS_BIT_CH1_GAIN];
      second_diag_gain4 <= acctl1_q[`AFS_BIT_CH2_GAIN];
    end
  end

  // return path, length and test current
  always_ff @(posedge clk) begin
    if (!nrst) begin
      impedance_test_return_path <= 1'b0;
      impedance_test_length      <= `AFS_LEN_SHORT;
      impedance_test_current     <= AFS_CUR_10MA;
    end else begin
      impedance_test_return_path <= acctl2_q[`AFS_BIT_LOOPBACK];
      impedance_test_length      <= length_d;
      impedance_test_current     <= current_d;
    end
  end
endmodule // afs_regs
